// *** lpwt_pkg.sv ***
// Purpose: Shared constants and types for the low power wakeup timer.
// Assumes: One system clock; the 32 kHz clock is sampled as a plain input.
// Notes: Register offsets are byte addresses on the simple register port.
//
// Behaviour
// - Count is 32 bits, incremented once per rising edge of the slow clock.
// - Counting starts at reset release and stops only in deepest power down; no enable exists.
// - Runs in all power states except deepest power down, where count is lost.
// - After light sleep exit, count is stale until one slow clock rising edge.
// - Compare event when count equals compare value on a slow clock rising edge.
// - Compare register resets to 0x0fffffff until software writes it.
// - Compare event can raise the interrupt and pulse a DMA trigger.
// - In either light sleep state a compare event requests wake-up.
// - Slow clock ticks give the second general timer its reference in sleep.
// - Capture only when armed; latch count on a slow clock rising edge while the selected pin flag is set.
// - Captured value is one more than the count at the pin event.
// - Capture valid status reads true once a value is captured since arming.

package lpwt_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_COUNT = 8'h00;
	localparam logic [7:0] OFF_COMPARE = 8'h04;
	localparam logic [7:0] OFF_CAPTURE = 8'h08;
	localparam logic [7:0] OFF_CAP_CTRL = 8'h0c;
	localparam logic [7:0] OFF_CAP_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFF_CLK_STAT = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CAP_CTRL_ARM_BIT = 0;
	localparam int CAP_CTRL_PIN_LSB = 4;
	localparam int PIN_SEL_W = 6;
	localparam int CAP_STAT_VALID_BIT = 0;
	localparam int CAP_STAT_ARMED_BIT = 1;
	localparam int IRQ_CMP_BIT = 0;
	localparam int IRQ_CAP_BIT = 1;
	localparam int IRQ_W = 2;
	localparam int CLK_STAT_SYNC_BIT = 0;
	localparam int NUM_PIN_FLAGS = 40;
	localparam logic [31:0] COMPARE_RESET = 32'h0fff_ffff;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
	localparam logic [31:0] CAPTURE_OFFSET = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} lpwt_bus_req_t;

	typedef struct packed {
		logic light_sleep_state_a;
		logic light_sleep_state_b;
		logic deepest_power_down_state;
	} lpwt_power_t;

endpackage : lpwt_pkg

// *** lpwt_tick.sv ***
// Purpose: Detects slow clock rising edges and keeps the sync flag.
// Assumes: low_speed_clock is synchronous to mclk and much slower.
// Notes: The flag drops in light sleep and rises on the first edge after.
`timescale 1ns/1ps

module lpwt_tick
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic low_speed_clock,
	input wire logic in_light_sleep,
	output logic tick,
	output logic low_clock_sync_flag
);

	logic clk_prev_reg;
	logic sync_reg;

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			clk_prev_reg <= 1'b0;
		else
			clk_prev_reg <= low_speed_clock;
	end

	assign tick = low_speed_clock & ~clk_prev_reg;

	// ----------------------------------------------------------------
	// Sync flag
	// ----------------------------------------------------------------
	// The system clock is stopped in light sleep, so the count seen on
	// exit may be stale; the flag says when the first edge has arrived.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			sync_reg <= 1'b0;
		else if (in_light_sleep)
			sync_reg <= 1'b0;
		else if (tick)
			sync_reg <= 1'b1;
	end

	assign low_clock_sync_flag = sync_reg;

endmodule : lpwt_tick

// *** lpwt_timer.sv ***
// Purpose: Low power wakeup timer with compare, capture and interrupts.
// Assumes: Registers reached over a simple strobe port, read data one cycle late.
// Notes: Power state inputs stand in for the real power controller.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module lpwt_timer
#(
	parameter int COUNT_W = 32
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire lpwt_pkg::lpwt_bus_req_t bus_req,
	output logic [lpwt_pkg::DATA_W-1:0] rd_data,
	input wire logic low_speed_clock,
	input wire lpwt_pkg::lpwt_power_t power_state,
	input wire logic [lpwt_pkg::NUM_PIN_FLAGS-1:0] pin_irq_flags,
	output logic irq,
	output logic dma_trigger,
	output logic wakeup_req,
	output logic timer2_ref_tick,
	output logic low_clock_sync_flag
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic tick;
	logic in_light_sleep;
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] compare_reg;
	logic [COUNT_W-1:0] capture_reg;
	logic [lpwt_pkg::PIN_SEL_W-1:0] pin_sel_reg;
	logic armed_reg;
	logic valid_reg;
	logic [lpwt_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [lpwt_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [lpwt_pkg::DATA_W-1:0] rd_data_reg;
	logic dma_reg;
	logic wake_reg;
	logic cmp_event;
	logic cap_event;
	logic arm_write;
	logic [lpwt_pkg::IRQ_W-1:0] irq_events;

	function automatic logic reg_hit(input lpwt_pkg::lpwt_bus_req_t req, input logic [7:0] off);
		reg_hit = (req.addr == off);
	endfunction : reg_hit

	assign in_light_sleep = power_state.light_sleep_state_a | power_state.light_sleep_state_b;

	lpwt_tick u_tick
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.low_speed_clock(low_speed_clock),
		.in_light_sleep(in_light_sleep),
		.tick(tick),
		.low_clock_sync_flag(low_clock_sync_flag)
	);

	// Each slow tick, except in deepest power down, also paces the second general timer while asleep.
	assign timer2_ref_tick = tick & ~power_state.deepest_power_down_state;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			count_reg <= lpwt_pkg::COUNT_RESET[COUNT_W-1:0];
		else if (power_state.deepest_power_down_state)
			count_reg <= lpwt_pkg::COUNT_RESET[COUNT_W-1:0];
		else if (tick)
			count_reg <= count_reg + lpwt_pkg::COUNT_STEP[COUNT_W-1:0];
	end

	// ----------------------------------------------------------------
	// Compare
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			compare_reg <= lpwt_pkg::COMPARE_RESET[COUNT_W-1:0];
		else if (bus_req.wr && reg_hit(bus_req, lpwt_pkg::OFF_COMPARE))
			compare_reg <= bus_req.wdata[COUNT_W-1:0];
	end

	// A value written too close to the count may already be passed by
	// the time it lands; software keeps a margin of five counts.
	assign cmp_event = tick && !power_state.deepest_power_down_state && (count_reg == compare_reg);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dma_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else
		begin
			dma_reg <= cmp_event;
			wake_reg <= cmp_event && in_light_sleep;
		end
	end

	assign dma_trigger = dma_reg;
	assign wakeup_req = wake_reg;

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	assign arm_write = bus_req.wr && reg_hit(bus_req, lpwt_pkg::OFF_CAP_CTRL);
	assign cap_event = armed_reg && tick && pin_irq_flags[pin_sel_reg];

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pin_sel_reg <= '0;
		else if (arm_write && !armed_reg)
			pin_sel_reg <= bus_req.wdata[lpwt_pkg::CAP_CTRL_PIN_LSB +: lpwt_pkg::PIN_SEL_W];
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			armed_reg <= 1'b0;
		else if (arm_write)
			armed_reg <= bus_req.wdata[lpwt_pkg::CAP_CTRL_ARM_BIT];
		else if (cap_event)
			armed_reg <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			valid_reg <= 1'b0;
		else if (arm_write && bus_req.wdata[lpwt_pkg::CAP_CTRL_ARM_BIT])
			valid_reg <= 1'b0;
		else if (cap_event && !arm_write)
			valid_reg <= 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			capture_reg <= '0;
		else if (cap_event && !arm_write)
			capture_reg <= count_reg + lpwt_pkg::CAPTURE_OFFSET[COUNT_W-1:0];
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_events[lpwt_pkg::IRQ_CMP_BIT] = cmp_event;
	assign irq_events[lpwt_pkg::IRQ_CAP_BIT] = cap_event && !arm_write;

	// A new event beats a write-one-to-clear in the same cycle.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			irq_stat_reg <= '0;
		else if (bus_req.wr && reg_hit(bus_req, lpwt_pkg::OFF_IRQ_STAT))
			irq_stat_reg <= (irq_stat_reg & ~bus_req.wdata[lpwt_pkg::IRQ_W-1:0]) | irq_events;
		else
			irq_stat_reg <= irq_stat_reg | irq_events;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			irq_mask_reg <= '0;
		else if (bus_req.wr && reg_hit(bus_req, lpwt_pkg::OFF_IRQ_MASK))
			irq_mask_reg <= bus_req.wdata[lpwt_pkg::IRQ_W-1:0];
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_reg <= '0;
		else if (bus_req.rd)
		begin
			case (bus_req.addr)
				lpwt_pkg::OFF_COUNT: rd_data_reg <= lpwt_pkg::DATA_W'(count_reg);
				lpwt_pkg::OFF_COMPARE: rd_data_reg <= lpwt_pkg::DATA_W'(compare_reg);
				lpwt_pkg::OFF_CAPTURE: rd_data_reg <= lpwt_pkg::DATA_W'(capture_reg);
				lpwt_pkg::OFF_CAP_CTRL: rd_data_reg <= lpwt_pkg::DATA_W'({pin_sel_reg, 3'h0, armed_reg});
				lpwt_pkg::OFF_CAP_STAT: rd_data_reg <= lpwt_pkg::DATA_W'({armed_reg, valid_reg});
				lpwt_pkg::OFF_IRQ_STAT: rd_data_reg <= lpwt_pkg::DATA_W'(irq_stat_reg);
				lpwt_pkg::OFF_IRQ_MASK: rd_data_reg <= lpwt_pkg::DATA_W'(irq_mask_reg);
				lpwt_pkg::OFF_CLK_STAT: rd_data_reg <= lpwt_pkg::DATA_W'(low_clock_sync_flag);
				default: rd_data_reg <= '0;
			endcase
		end
		else
			rd_data_reg <= '0;
	end

	assign rd_data = rd_data_reg;

endmodule : lpwt_timer

// *** lpwt_timer_properties.sv ***
// Purpose: Port-level assertions for the low power wakeup timer.
// Assumes: Slow clock edges are at least two system cycles apart.
// Notes: Bound to every instance of lpwt_timer.
`timescale 1ns/1ps

module lpwt_timer_properties
#(
	parameter int COUNT_W = 32
)
(
	input logic mclk,
	input logic rst_n,
	input lpwt_pkg::lpwt_bus_req_t bus_req,
	input logic [lpwt_pkg::DATA_W-1:0] rd_data,
	input logic low_speed_clock,
	input lpwt_pkg::lpwt_power_t power_state,
	input logic [lpwt_pkg::NUM_PIN_FLAGS-1:0] pin_irq_flags,
	input logic irq,
	input logic dma_trigger,
	input logic wakeup_req,
	input logic timer2_ref_tick,
	input logic low_clock_sync_flag
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic sleep;
	assign sleep = power_state.light_sleep_state_a | power_state.light_sleep_state_b;

	chk_dma_single: assert property (dma_trigger |=> !dma_trigger)
		else $error("dma trigger longer than one cycle");
	chk_dma_cause: assert property (dma_trigger |-> $past(low_speed_clock) && !$past(low_speed_clock, 2))
		else $error("dma trigger without a slow clock edge");
	chk_wake_sleep: assert property (wakeup_req |-> dma_trigger && $past(sleep))
		else $error("wake request outside light sleep");
	chk_ref_edge: assert property (timer2_ref_tick |-> low_speed_clock && !$past(low_speed_clock)
		&& !power_state.deepest_power_down_state)
		else $error("reference tick without slow clock edge");
	chk_sync_rise: assert property ($rose(low_clock_sync_flag) |-> $past(low_speed_clock)
		&& !$past(low_speed_clock, 2) && !$past(sleep))
		else $error("sync flag rose without slow clock edge");
	chk_sync_sleep: assert property (sleep ##1 sleep |-> !low_clock_sync_flag)
		else $error("sync flag high in light sleep");
	chk_irq_rise: assert property ($rose(irq) |-> $past(bus_req.wr)
		|| ($past(low_speed_clock) && !$past(low_speed_clock, 2)))
		else $error("interrupt rose without cause");
	chk_irq_fall: assert property ($fell(irq) |-> $past(bus_req.wr))
		else $error("interrupt fell without a write");
	chk_read_idle: assert property (!$past(bus_req.rd) |-> rd_data == '0)
		else $error("read data not zero outside read cycle");
	chk_deep_zero: assert property ($past(bus_req.rd && bus_req.addr == lpwt_pkg::OFF_COUNT
		&& power_state.deepest_power_down_state) && $past(power_state.deepest_power_down_state, 2)
		|-> rd_data == '0)
		else $error("count not zero in deepest state");

	cov_dma: cover property (dma_trigger);
	cov_wake: cover property (wakeup_req);
	cov_irq: cover property ($rose(irq));
	cov_sync: cover property ($rose(low_clock_sync_flag));
endmodule : lpwt_timer_properties

bind lpwt_timer lpwt_timer_properties #(.COUNT_W(COUNT_W)) chk_u (.mclk(mclk), .rst_n(rst_n),
	.bus_req(bus_req), .rd_data(rd_data), .low_speed_clock(low_speed_clock), .power_state(power_state),
	.pin_irq_flags(pin_irq_flags), .irq(irq), .dma_trigger(dma_trigger), .wakeup_req(wakeup_req),
	.timer2_ref_tick(timer2_ref_tick), .low_clock_sync_flag(low_clock_sync_flag));

// *** test_low_power_wakeup_timer.sv ***
// Purpose: Self-checking bench for the low power wakeup timer.
// Assumes: Slow clock is driven by the bench, four system cycles a period.
// Notes: Compare values stay five counts ahead, so no event can be missed.
`timescale 1ns/1ps

module test_low_power_wakeup_timer;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	lpwt_pkg::lpwt_bus_req_t bus_req = '0;
	logic [31:0] rd_data;
	logic low_speed_clock = 1'b0;
	lpwt_pkg::lpwt_power_t power_state = '0;
	logic [lpwt_pkg::NUM_PIN_FLAGS-1:0] pin_irq_flags = '0;
	logic irq, dma_trigger, wakeup_req, timer2_ref_tick, low_clock_sync_flag;
	int fails = 0, comparisons = 0, cyc = 0, dma_n = 0, wake_n = 0, ref_n = 0, tk = 0;
	logic [31:0] cnt = '0, d;

	always #2 mclk = ~mclk;

	lpwt_timer dut_u (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.low_speed_clock(low_speed_clock), .power_state(power_state), .pin_irq_flags(pin_irq_flags),
		.irq(irq), .dma_trigger(dma_trigger), .wakeup_req(wakeup_req),
		.timer2_ref_tick(timer2_ref_tick), .low_clock_sync_flag(low_clock_sync_flag));

	// Pulses last one cycle, so they are counted here rather than polled by the scenarios.
	always @(posedge mclk)
	begin
		cyc++;
		dma_n += dma_trigger;
		wake_n += wakeup_req;
		ref_n += timer2_ref_tick;
		if (cyc == 5000)
		begin
			fails++;
			summarize();
		end
	end

	task summarize;
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v);
		bus_req.addr <= a;
		bus_req.wdata <= v;
		bus_req.wr <= 1'b1;
		@(posedge mclk);
		bus_req.wr <= 1'b0;
		@(posedge mclk);
	endtask : wr

	task rd(input logic [7:0] a);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1 d = rd_data;
		@(posedge mclk);
	endtask : rd

	task tick(input int n);
		repeat (n)
		begin
			low_speed_clock <= 1'b1;
			repeat (2) @(posedge mclk);
			low_speed_clock <= 1'b0;
			repeat (2) @(posedge mclk);
			if (!power_state.deepest_power_down_state)
			begin
				cnt++;
				tk++;
			end
		end
	endtask : tick

	task t_reset;
		rd(lpwt_pkg::OFF_COMPARE);
		chk(d, 32'h0fff_ffff);
		rd(8'h20);
		chk(d, 32'h0);
		rd(lpwt_pkg::OFF_COUNT);
		chk(d, 32'h0);
		tick(3);
		rd(lpwt_pkg::OFF_COUNT);
		chk(d, cnt);
	endtask : t_reset

	task t_compare;
		wr(lpwt_pkg::OFF_COMPARE, cnt + 32'h5);
		tick(5);
		chk(dma_n, 32'h0);
		tick(1);
		chk(dma_n, 32'h1);
		chk(wake_n, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd(lpwt_pkg::OFF_IRQ_STAT);
		chk(d, 32'h1);
		wr(lpwt_pkg::OFF_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(lpwt_pkg::OFF_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
	endtask : t_compare

	task t_sleep;
		for (int i = 0; i < 2; i++)
		begin
			power_state <= (i == 0) ? 3'h4 : 3'h2;
			wr(lpwt_pkg::OFF_COMPARE, cnt + 32'h5);
			tick(6);
			chk(wake_n, i + 1);
			rd(lpwt_pkg::OFF_CLK_STAT);
			chk(d, 32'h0);
			power_state <= '0;
			rd(lpwt_pkg::OFF_CLK_STAT);
			chk(d, 32'h0);
			tick(1);
			rd(lpwt_pkg::OFF_CLK_STAT);
			chk(d, 32'h1);
			rd(lpwt_pkg::OFF_COUNT);
			chk(d, cnt);
			wr(lpwt_pkg::OFF_IRQ_STAT, 32'h1);
		end
	endtask : t_sleep

	task t_capture;
		wr(lpwt_pkg::OFF_CAP_CTRL, 32'h51);
		tick(1);
		rd(lpwt_pkg::OFF_CAP_STAT);
		chk(d, 32'h2);
		pin_irq_flags[5] <= 1'b1;
		tick(1);
		pin_irq_flags[5] <= 1'b0;
		rd(lpwt_pkg::OFF_CAPTURE);
		chk(d, cnt);
		rd(lpwt_pkg::OFF_CAP_STAT);
		chk(d, 32'h1);
		rd(lpwt_pkg::OFF_IRQ_STAT);
		chk(d, 32'h2);
		tick(1);
		rd(lpwt_pkg::OFF_CAPTURE);
		chk(d, cnt - 32'h1);
		wr(lpwt_pkg::OFF_CAP_CTRL, 32'h51);
		rd(lpwt_pkg::OFF_CAP_STAT);
		chk(d, 32'h2);
		wr(lpwt_pkg::OFF_CAP_CTRL, 32'h71);
		rd(lpwt_pkg::OFF_CAP_CTRL);
		chk(d, 32'h51);
		wr(lpwt_pkg::OFF_CAP_CTRL, 32'h0);
		wr(lpwt_pkg::OFF_IRQ_STAT, 32'h3);
	endtask : t_capture

	task t_deep;
		power_state <= 3'h1;
		tick(3);
		rd(lpwt_pkg::OFF_COUNT);
		chk(d, 32'h0);
		chk(ref_n, tk);
		power_state <= '0;
		cnt = '0;
		tick(2);
		rd(lpwt_pkg::OFF_COUNT);
		chk(d, cnt);
	endtask : t_deep

	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_compare();
		t_sleep();
		t_capture();
		t_deep();
		summarize();
	end
endmodule : test_low_power_wakeup_timer
